// file: common/cssut_pkg.sv
// Constants and carrier types for the clock source, start-up and trim block
package cssut_pkg;
    // Clock source select fuse codes (0 = programmed, 1 = unprogrammed)
    localparam logic [1:0] CSSUT_SRC_EXTERNAL = 2'h0;
    localparam logic [1:0] CSSUT_SRC_RC_4M8 = 2'h1;
    localparam logic [1:0] CSSUT_SRC_RC_9M6 = 2'h2;
    localparam logic [1:0] CSSUT_SRC_LOWFREQ = 2'h3;
    // Start-up time fuse codes
    localparam logic [1:0] CSSUT_SUT_SHORT = 2'h0;
    localparam logic [1:0] CSSUT_SUT_4MS = 2'h1;
    localparam logic [1:0] CSSUT_SUT_64MS = 2'h2;
    localparam logic [1:0] CSSUT_SUT_RESERVED = 2'h3;
    // Delivered fuse defaults
    localparam logic [1:0] CSSUT_DEFAULT_SRC = 2'h2;
    localparam logic [1:0] CSSUT_DEFAULT_SUT = 2'h2;
    localparam logic CSSUT_FUSE_PROGRAMMED = 1'h0;
    localparam logic CSSUT_DEFAULT_DIV8 = 1'h0;
    // Nominal RC frequencies in kHz
    localparam int CSSUT_RC_HIGH_KHZ = 9600;
    localparam int CSSUT_RC_LOW_KHZ = 4800;
    // Start-up cycle counts of the selected source
    localparam logic [4:0] CSSUT_WAKE_CYCLES = 5'h06;
    localparam logic [4:0] CSSUT_RESET_CYCLES = 5'h0E;
    localparam int CSSUT_CNT_W = 5;
    // Watchdog oscillator cycles for the real-time reset delay
    localparam int CSSUT_WDG_W = 14;
    localparam logic [13:0] CSSUT_WDG_4MS_CYCLES = 14'h0200;
    localparam logic [13:0] CSSUT_WDG_64MS_CYCLES = 14'h2000;
    // Trim register layout
    localparam int CSSUT_TRIM_W = 7;
    localparam int CSSUT_TRIM_MSB = 6;
    localparam int CSSUT_TRIM_RSVD_BIT = 7;
    localparam logic [6:0] CSSUT_TRIM_MIN = 7'h00;
    localparam logic [6:0] CSSUT_TRIM_MID = 7'h3F;
    localparam logic [6:0] CSSUT_TRIM_MAX = 7'h7F;
    // Prescale select reset values
    localparam logic [3:0] CSSUT_PRESCALE_DIV8 = 4'h3;
    localparam logic [3:0] CSSUT_PRESCALE_DIV1 = 4'h0;

    typedef struct packed {
        logic [1:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic divide_by_eight_fuse;
    } cssut_fuse_type;

    typedef struct packed {
        logic core_clock;
        logic peripheral_clock;
        logic program_memory_clock;
        logic converter_clock;
    } cssut_clock_enable_type;

    typedef enum logic [4:0] {
        CSSUT_ST_RESET = 5'b00001,
        CSSUT_ST_OSC_COUNT = 5'b00010,
        CSSUT_ST_WDG_WAIT = 5'b00100,
        CSSUT_ST_RUN = 5'b01000,
        CSSUT_ST_ASLEEP = 5'b10000
    } cssut_state_type;
endpackage

// file: hw/cssut_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module cssut_sync
    import cssut_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_level,
    output logic sync_level
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 1'b0;
            sync_level <= 1'b0;
        end
        else
        begin
            stage1 <= async_level;
            sync_level <= stage1;
        end
    end
endmodule

// file: hw/cssut_wdg_timer.sv
// Watchdog oscillator cycle counter for the real-time reset delay
`timescale 1ns/1ps
module cssut_wdg_timer
    import cssut_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [CSSUT_WDG_W-1:0] target,
    input wire logic wdg_tick,
    output logic done
);
    logic [CSSUT_WDG_W-1:0] count;
    logic running;

    // Counts synchronised edges of the separate watchdog oscillator
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start)
            begin
                count <= '0;
                running <= 1'b1;
                done <= 1'b0;
            end
            else if (running && wdg_tick)
            begin
                if (count == target - 14'h0001)
                begin
                    running <= 1'b0;
                    done <= 1'b1;
                end
                count <= count + 14'h0001;
            end
        end
    end
endmodule

// file: hw/cssut_clock_control.sv
// Clock source selection, start-up sequencing, trim and clock gating
`timescale 1ns/1ps
module cssut_clock_control
    import cssut_pkg::*;
#(
    parameter logic [1:0] FUSE_SOURCE_DEFAULT = CSSUT_DEFAULT_SRC,
    parameter logic [1:0] FUSE_STARTUP_DEFAULT = CSSUT_DEFAULT_SUT
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire cssut_fuse_type fuses,
    input wire logic [CSSUT_TRIM_W-1:0] factory_trim,
    input wire logic wdg_osc_clk,
    input wire logic sleep_request,
    input wire logic [1:0] sleep_mode,
    input wire logic wake_event,
    input wire logic async_irq_pin,
    input wire logic trim_write,
    input wire logic [7:0] trim_write_data,
    output logic [7:0] oscillator_trim_register,
    output logic [CSSUT_TRIM_W-1:0] trim_value_field,
    output logic [1:0] source_sel,
    output logic rc_high_freq,
    output logic startup_reserved,
    output logic [3:0] prescale_select_field,
    output cssut_clock_enable_type clock_enables,
    output logic core_running,
    output logic async_irq_wake
);
    cssut_state_type state;
    cssut_fuse_type fuse_latch;
    logic fuse_captured;
    logic [CSSUT_CNT_W-1:0] osc_count;
    logic [CSSUT_CNT_W-1:0] osc_target;
    logic wdg_sync;
    logic wdg_prev;
    logic wdg_tick;
    logic wdg_start;
    logic wdg_done;
    logic [CSSUT_WDG_W-1:0] wdg_target;
    logic need_wdg;
    logic irq_sync;
    logic irq_latched;
    logic cold_start;
    logic [1:0] sleep_mode_held;

    // Sleep mode codes: 0 idle, 1 converter noise reduction, 2 power-down
    localparam logic [1:0] SLEEP_IDLE = 2'h0;
    localparam logic [1:0] SLEEP_NOISE = 2'h1;

    // Watchdog oscillator runs on its own; sample it before use
    cssut_sync u_wdg_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_level(wdg_osc_clk),
        .sync_level(wdg_sync)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wdg_prev <= 1'b0;
        else if (clk_en)
            wdg_prev <= wdg_sync;
    end

    assign wdg_tick = wdg_sync & ~wdg_prev;

    // Real-time reset delay in watchdog oscillator cycles
    always_comb
    begin
        wdg_target = CSSUT_WDG_4MS_CYCLES;
        need_wdg = 1'b0;
        if (fuse_latch.startup_time_fuses == CSSUT_SUT_4MS)
        begin
            wdg_target = CSSUT_WDG_4MS_CYCLES;
            need_wdg = 1'b1;
        end
        else if (fuse_latch.startup_time_fuses == CSSUT_SUT_64MS)
        begin
            wdg_target = CSSUT_WDG_64MS_CYCLES;
            need_wdg = 1'b1;
        end
    end

    cssut_wdg_timer u_wdg_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .start(wdg_start),
        .target(wdg_target),
        .wdg_tick(wdg_tick),
        .done(wdg_done)
    );

    // Fuses are caught by a clocked process after reset release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fuse_latch <= {FUSE_SOURCE_DEFAULT, FUSE_STARTUP_DEFAULT,
                CSSUT_DEFAULT_DIV8};
            fuse_captured <= 1'b0;
        end
        else if (clk_en && !fuse_captured)
        begin
            fuse_latch <= fuses;
            fuse_captured <= 1'b1;
        end
    end

    // Source decode from the fuse field
    assign source_sel = fuse_latch.clock_source_select_fuses;
    assign rc_high_freq =
        (fuse_latch.clock_source_select_fuses == CSSUT_SRC_RC_9M6);
    assign startup_reserved =
        (fuse_latch.startup_time_fuses == CSSUT_SUT_RESERVED);

    // Start-up cycle target: 14 after reset, 6 after wake
    assign osc_target = cold_start ? CSSUT_RESET_CYCLES : CSSUT_WAKE_CYCLES;
    assign wdg_start = (state == CSSUT_ST_OSC_COUNT) &&
        (osc_count == osc_target - 5'h01) && cold_start && need_wdg;

    // Start-up sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= CSSUT_ST_RESET;
            osc_count <= '0;
            cold_start <= 1'b1;
        end
        else if (clk_en)
        begin
            unique case (state)
                CSSUT_ST_RESET:
                begin
                    // Reserved start-up code stalls here, all gated
                    if (fuse_captured && !startup_reserved)
                    begin
                        osc_count <= '0;
                        state <= CSSUT_ST_OSC_COUNT;
                    end
                end
                CSSUT_ST_OSC_COUNT:
                begin
                    osc_count <= osc_count + 5'h01;
                    if (osc_count == osc_target - 5'h01)
                    begin
                        if (cold_start && need_wdg)
                            state <= CSSUT_ST_WDG_WAIT;
                        else
                            state <= CSSUT_ST_RUN;
                    end
                end
                CSSUT_ST_WDG_WAIT:
                begin
                    if (wdg_done)
                        state <= CSSUT_ST_RUN;
                end
                CSSUT_ST_RUN:
                begin
                    cold_start <= 1'b0;
                    if (sleep_request)
                        state <= CSSUT_ST_ASLEEP;
                end
                CSSUT_ST_ASLEEP:
                begin
                    if (wake_event || irq_latched)
                    begin
                        osc_count <= '0;
                        if (sleep_mode_held == SLEEP_IDLE ||
                            sleep_mode_held == SLEEP_NOISE)
                            state <= CSSUT_ST_RUN;
                        else
                            state <= CSSUT_ST_OSC_COUNT;
                    end
                end
            endcase
        end
    end

    assign core_running = (state == CSSUT_ST_RUN);

    // Mode is held from the edge that takes the request, so a moving
    // mode input cannot reopen gated domains or change the wake path
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sleep_mode_held <= SLEEP_IDLE;
        else if (clk_en && state == CSSUT_ST_RUN && sleep_request)
            sleep_mode_held <= sleep_mode;
    end

    // Clock gating per domain
    always_comb
    begin
        clock_enables = '0;
        unique case (state)
            CSSUT_ST_RUN:
            begin
                clock_enables.core_clock = 1'b1;
                clock_enables.program_memory_clock = 1'b1;
                clock_enables.peripheral_clock = 1'b1;
                clock_enables.converter_clock = 1'b1;
            end
            CSSUT_ST_ASLEEP:
            begin
                clock_enables.peripheral_clock =
                    (sleep_mode_held == SLEEP_IDLE);
                clock_enables.converter_clock =
                    (sleep_mode_held == SLEEP_IDLE) ||
                    (sleep_mode_held == SLEEP_NOISE);
            end
            CSSUT_ST_RESET,
            CSSUT_ST_OSC_COUNT,
            CSSUT_ST_WDG_WAIT:
            begin
                // Nothing runs until the start-up delay is over
                clock_enables = '0;
            end
        endcase
    end

    // Interrupt pin seen without the peripheral clock
    cssut_sync u_irq_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_level(async_irq_pin),
        .sync_level(irq_sync)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_latched <= 1'b0;
        else if (clk_en)
        begin
            if (irq_sync && state == CSSUT_ST_ASLEEP)
                irq_latched <= 1'b1;
            else if (state != CSSUT_ST_ASLEEP)
                irq_latched <= 1'b0;
        end
    end

    assign async_irq_wake = irq_latched;

    // Trim register: mid value at reset, factory load on the first enabled edge after release, then software writes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            trim_value_field <= CSSUT_TRIM_MID;
        else if (clk_en)
        begin
            if (state == CSSUT_ST_RESET && !fuse_captured)
                trim_value_field <= factory_trim;
            else if (trim_write)
                trim_value_field <= trim_write_data[CSSUT_TRIM_MSB:0];
        end
    end

    // Bit 7 reads zero; trim code is monotonic in frequency
    // The field drives the oscillator trim directly: 0x00 is the low end,
    // 0x3F the middle and 0x7F the top of the tuning span
    assign oscillator_trim_register = {1'b0, trim_value_field};

    // Prescale select reset value follows divide-by-eight fuse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prescale_select_field <= CSSUT_PRESCALE_DIV8;
        else if (clk_en && state == CSSUT_ST_RESET && !fuse_captured)
        begin
            if (fuses.divide_by_eight_fuse == CSSUT_FUSE_PROGRAMMED)
                prescale_select_field <= CSSUT_PRESCALE_DIV8;
            else
                prescale_select_field <= CSSUT_PRESCALE_DIV1;
        end
    end
endmodule

// file: testbench/cssut_clock_control_properties.sv
// Concurrent checks on the ports of the clock control block
`timescale 1ns/1ps
module cssut_clock_control_properties
    import cssut_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sleep_request,
    input wire logic [1:0] sleep_mode,
    input wire logic trim_write,
    input wire logic [7:0] trim_write_data,
    input wire logic [7:0] oscillator_trim_register,
    input wire logic [CSSUT_TRIM_W-1:0] trim_value_field,
    input wire logic [1:0] source_sel,
    input wire logic rc_high_freq,
    input wire logic startup_reserved,
    input wire cssut_clock_enable_type clock_enables,
    input wire logic core_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sleep_idle;
        core_running && clk_en && sleep_request && sleep_mode == 2'h0
        ##1 !core_running;
    endsequence

    sequence s_sleep_noise;
        core_running && clk_en && sleep_request && sleep_mode == 2'h1
        ##1 !core_running;
    endsequence

    sequence s_power_down;
        core_running && clk_en && sleep_request && sleep_mode[1]
        ##1 !core_running;
    endsequence

    a_trim_rsvd_zero: assert property (
        oscillator_trim_register == {1'b0, trim_value_field})
        else $error("trim register bit 7 set or field mismatch");
    a_trim_write_lands: assert property (
        clk_en && trim_write && core_running
        |=> {1'b0, trim_value_field} == ($past(trim_write_data) & 8'h7F))
        else $error("trim write not applied");
    a_memory_follows_core: assert property (
        clock_enables.program_memory_clock == clock_enables.core_clock)
        else $error("program memory clock differs from core clock");
    a_core_gate_start: assert property (
        clock_enables.core_clock == core_running)
        else $error("core clock runs outside run state");
    a_run_all_clocks: assert property (
        core_running |-> clock_enables == 4'hF)
        else $error("clock missing while running");
    a_rc_high_decode: assert property (
        rc_high_freq == (source_sel == CSSUT_SRC_RC_9M6))
        else $error("high frequency flag does not match source");
    a_reserved_stalls: assert property (
        startup_reserved |-> !core_running)
        else $error("reserved start-up code reached run");
    a_idle_gating: assert property (
        s_sleep_idle |-> clock_enables == 4'h5)
        else $error("idle sleep gating wrong");
    a_noise_gating: assert property (
        s_sleep_noise |-> clock_enables == 4'h1)
        else $error("noise reduction gating wrong");
    a_pdown_wake_time: assert property (s_power_down
        |-> clock_enables == 4'h0 ##1 (!core_running) [*5])
        else $error("power-down wake too early or clocks on");
endmodule

bind cssut_clock_control cssut_clock_control_properties i_props (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .sleep_request(sleep_request), .sleep_mode(sleep_mode),
    .trim_write(trim_write), .trim_write_data(trim_write_data),
    .oscillator_trim_register(oscillator_trim_register),
    .trim_value_field(trim_value_field), .source_sel(source_sel),
    .rc_high_freq(rc_high_freq), .startup_reserved(startup_reserved),
    .clock_enables(clock_enables), .core_running(core_running)
);

// file: testbench/testbench.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module testbench
    import cssut_pkg::*;
;
    logic clk = 0, rst_n = 0, clk_en = 1, wdg_osc_clk = 0;
    cssut_fuse_type fuses = '0;
    logic [6:0] factory_trim = '0;
    logic sleep_request = 0, wake_event = 0, async_irq_pin = 0;
    logic trim_write = 0;
    logic [1:0] sleep_mode = '0;
    logic [7:0] trim_write_data = '0, trim_reg;
    logic [6:0] trim_field;
    logic [1:0] source_sel;
    logic rc_high_freq, startup_reserved, core_running, async_irq_wake;
    logic [3:0] prescale;
    cssut_clock_enable_type clock_enables;
    int n_errors = 0, comparisons = 0, ticks = 0, n, t0;
    logic [31:0] seed = 32'h000157A6;
    logic [31:0] r;
    logic [6:0] tv, tv_next;

    cssut_clock_control i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .fuses(fuses), .factory_trim(factory_trim),
        .wdg_osc_clk(wdg_osc_clk), .sleep_request(sleep_request),
        .sleep_mode(sleep_mode), .wake_event(wake_event),
        .async_irq_pin(async_irq_pin), .trim_write(trim_write),
        .trim_write_data(trim_write_data),
        .oscillator_trim_register(trim_reg), .trim_value_field(trim_field),
        .source_sel(source_sel), .rc_high_freq(rc_high_freq),
        .startup_reserved(startup_reserved),
        .prescale_select_field(prescale), .clock_enables(clock_enables),
        .core_running(core_running), .async_irq_wake(async_irq_wake));

    initial forever #4 clk = ~clk;
    // Watchdog oscillator, unrelated in phase to the system clock
    initial forever #13 wdg_osc_clk = ~wdg_osc_clk;
    always @(posedge wdg_osc_clk) ticks++;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [3:0] exp_gate(input logic [1:0] m);
        return m == 2'h0 ? 4'h5 : (m == 2'h1 ? 4'h1 : 4'h0);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic in_range(input int v, input int lo, input int hi);
        comparisons++;
        if (v < lo || v > hi)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h to %h", $time,
                v, lo, hi);
        end
    endtask

    // One trim write; the strobe stays up between back-to-back writes
    task automatic trim_step(input logic [6:0] v, input logic b7);
        trim_write = 1;
        trim_write_data = {b7, v};
        @(negedge clk);
        check(trim_reg, {1'b0, v});
        tv = v;
    endtask

    // Walks the trim to a target in steps of at most 0x20
    task automatic trim_walk(input logic [6:0] t);
        while (tv != t)
            if (tv > t)
                trim_step(tv - t > 7'h20 ? tv - 7'h20 : t, 1'b0);
            else
                trim_step(t - tv > 7'h20 ? tv + 7'h20 : t, 1'b0);
    endtask

    task automatic do_reset(input logic [1:0] s, input logic [1:0] u,
                            input logic d, input logic [6:0] t);
        @(negedge clk);
        rst_n = 0;
        fuses = cssut_fuse_type'({s, u, d});
        factory_trim = t;
        repeat (5) @(negedge clk);
        check(clock_enables, 16'h0000);
        rst_n = 1;
        t0 = ticks;
    endtask

    task automatic wait_run(input int lim, output int cnt);
        cnt = 0;
        while (core_running !== 1'b1 && cnt < lim)
        begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        for (int s = 0; s < 4; s++)
        begin
            r = xs();
            do_reset(s[1:0], CSSUT_SUT_SHORT, r[7], r[6:0]);
            wait_run(40, n);
            in_range(n, 14, 18);
            check(source_sel, s[1:0]);
            check(rc_high_freq, s == 2);
            check(trim_reg, {1'b0, r[6:0]});
            check(prescale, r[7] ? 4'h0 : 4'h3);
            check(clock_enables, 16'h000F);
        end
        $display("source select test done");
        for (int u = 1; u < 3; u++)
        begin
            do_reset(CSSUT_DEFAULT_SRC, u[1:0], CSSUT_DEFAULT_DIV8, 7'h2A);
            wait_run(40000, n);
            n = ticks - t0;
            in_range(n, u == 1 ? 512 : 8192, u == 1 ? 530 : 8210);
            check(prescale, CSSUT_PRESCALE_DIV8);
        end
        check(rc_high_freq, 16'h0001);
        $display("watchdog delay test done");
        do_reset(CSSUT_SRC_RC_4M8, CSSUT_SUT_RESERVED, 1'b1, 7'h11);
        wait_run(60, n);
        check(core_running, 16'h0000);
        check(startup_reserved, 16'h0001);
        $display("reserved start-up test done");
        do_reset(CSSUT_SRC_RC_9M6, CSSUT_SUT_SHORT, 1'b0, 7'h40);
        wait_run(40, n);
        tv = 7'h40;
        for (int i = 0; i < 24; i++)
        begin
            r = xs();
            if (r[6] ? tv > 7'h5F : tv < 7'h20)
                r[6] = ~r[6];
            tv_next = r[6] ? tv + {2'b00, r[4:0]} : tv - {2'b00, r[4:0]};
            trim_step(tv_next, i == 0 || r[7]);
        end
        trim_walk(CSSUT_TRIM_MIN);
        check(trim_field, CSSUT_TRIM_MIN);
        trim_walk(CSSUT_TRIM_MID);
        check(trim_field, CSSUT_TRIM_MID);
        // No memory write runs here, so trimming far above nominal is safe
        trim_walk(CSSUT_TRIM_MAX);
        check(trim_reg, 16'h007F);
        clk_en = 0;
        trim_write_data = 8'h60;
        @(negedge clk);
        check(trim_reg, 16'h007F);
        trim_write = 0;
        clk_en = 1;
        $display("trim write test done");
        for (int m = 0; m < 4; m++)
        begin
            sleep_mode = m[1:0];
            sleep_request = 1;
            @(negedge clk);
            sleep_request = 0;
            repeat (2) @(negedge clk);
            check(clock_enables, exp_gate(m[1:0]));
            if (m == 3)
            begin
                async_irq_pin = 1;
                repeat (3) @(negedge clk);
                check(async_irq_wake, 16'h0001);
            end
            else
                wake_event = 1;
            wait_run(30, n);
            check(async_irq_wake, 16'h0000);
            async_irq_pin = 0;
            wake_event = 0;
            if (m < 2)
                in_range(n, 1, 3);
            else if (m == 2)
                in_range(n, 6, 9);
            else
                in_range(n, 6, 16);
            @(negedge clk);
        end
        $display("sleep and wake test done");
        end_of_test();
    end
endmodule
